// >>> verilog/etd_cfg.svh
`ifndef ETD_CFG_SVH
`define ETD_CFG_SVH
// What this block does
// - A descriptor spans eight consecutive 32-bit words; the engine steps by that size.
// - Ownership bit 31 set means engine owns it; clear means host, engine suspends there.
// - Engine clears ownership after the frame is sent or the buffers are emptied.
// - Completion-interrupt bit 30 with final segment sets status register 5 bit 0.
// - Final segment bit 29; host gives a non-zero buffer size then.
// - Initial segment bit 28 starts a new frame.
// - Frame options are taken only from a descriptor with bit 28 set.
// - Bit 27 set stops the computed CRC being appended, unless padding applies.
// - Bit 26 set stops padding short frames; clear pads them to 64 bytes.
// - Bit 25 requests a hardware timestamp for this frame.
// - Bits 24 and 27 both set make the MAC overwrite the last four bytes.
// - Checksum mode 00 is off; 01 inserts the IP header checksum only.
// - Mode 10 adds payload checksum; 11 also sums the pseudo-header in hardware.
// - Ring-wrap bit 21 makes the next fetch come from the list base address.
// - Chained bit 20 makes word 3 the next address; second size is ignored.
// - With bits 21 and 20 both set, ring wrap wins.

`define ETD_DESC_BYTES   32'h0000_0020
`define ETD_OWN_BIT      31
`define ETD_IRQ_BIT      30
`define ETD_LAST_BIT     29
`define ETD_FIRST_BIT    28
`define ETD_NOCRC_BIT    27
`define ETD_NOPAD_BIT    26
`define ETD_STAMP_BIT    25
`define ETD_CRCOVR_BIT   24
`define ETD_CSUM_MSB     23
`define ETD_CSUM_LSB     22
`define ETD_WRAP_BIT     21
`define ETD_CHAIN_BIT    20
`define ETD_SIZE1_MSB    12
`define ETD_SIZE1_LSB    0
`define ETD_SIZE2_MSB    28
`define ETD_SIZE2_LSB    16
`define ETD_MIN_FRAME    8'h40

`define ETD_REG_CTRL     8'h00
`define ETD_REG_BASE     8'h04
`define ETD_REG_POLL     8'h08
`define ETD_REG_STATUS   8'h14
`define ETD_REG_CUR      8'h18
`define ETD_CTRL_EN_BIT  0
`define ETD_ST_DONE_BIT  0
`define ETD_ST_SUSP_BIT  2
`define ETD_RST_BASE     32'h0000_0000
`endif

// >>> verilog/etd_pkg.sv
package etd_pkg;
    typedef enum logic [6:0] {
        ETD_IDLE  = 7'b0000001,
        ETD_RD    = 7'b0000010,
        ETD_RWAIT = 7'b0000100,
        ETD_BUF   = 7'b0001000,
        ETD_SENT  = 7'b0010000,
        ETD_WB    = 7'b0100000,
        ETD_SUSP  = 7'b1000000
    } etd_state_t;

    typedef enum logic [1:0] {
        ETD_CSUM_OFF  = 2'h0,
        ETD_CSUM_HDR  = 2'h1,
        ETD_CSUM_FULL = 2'h2,
        ETD_CSUM_PSEU = 2'h3
    } etd_csum_t;
endpackage

// >>> verilog/etd_dec_if.sv
interface etd_dec_if;
    logic                    [31:0] word0;
    logic                           own;
    logic                           irq_when_sent;
    logic                           final_segment_flag;
    logic                           initial_segment_flag;
    logic                           crc_append;
    logic                           pad_enable;
    logic                           pad_crc;
    logic                           tx_stamp_request;
    logic                           crc_overwrite_request;
    etd_pkg::etd_csum_t             checksum_insert_mode;
    logic                           ring_wrap_flag;
    logic                           chained_next_address_flag;
    logic                           use_chain;

    modport dec (
        input  word0,
        output own, irq_when_sent, final_segment_flag, initial_segment_flag, crc_append,
        output pad_enable, pad_crc, tx_stamp_request, crc_overwrite_request,
        output checksum_insert_mode, ring_wrap_flag, chained_next_address_flag, use_chain
    );
    modport eng (
        output word0,
        input  own, irq_when_sent, final_segment_flag, initial_segment_flag, crc_append,
        input  pad_enable, pad_crc, tx_stamp_request, crc_overwrite_request,
        input  checksum_insert_mode, ring_wrap_flag, chained_next_address_flag, use_chain
    );
endinterface

// >>> verilog/etd_word0_dec.sv
`include "etd_cfg.svh"
module etd_word0_dec (
    etd_dec_if.dec d
);
    always_comb begin
        d.own                       = d.word0[`ETD_OWN_BIT];
        d.irq_when_sent             = d.word0[`ETD_IRQ_BIT];
        d.final_segment_flag        = d.word0[`ETD_LAST_BIT];
        d.initial_segment_flag      = d.word0[`ETD_FIRST_BIT];
        d.crc_append                = ~d.word0[`ETD_NOCRC_BIT];
        d.pad_enable                = ~d.word0[`ETD_NOPAD_BIT];
        // Padding needs a CRC after it, so the no-CRC bit cannot suppress it.
        d.pad_crc                   = ~d.word0[`ETD_NOPAD_BIT];
        d.tx_stamp_request          = d.word0[`ETD_STAMP_BIT];
        d.crc_overwrite_request     = d.word0[`ETD_CRCOVR_BIT]
                                      & d.word0[`ETD_NOCRC_BIT];
        d.checksum_insert_mode      = etd_pkg::etd_csum_t'(
                                      d.word0[`ETD_CSUM_MSB:`ETD_CSUM_LSB]);
        d.ring_wrap_flag            = d.word0[`ETD_WRAP_BIT];
        d.chained_next_address_flag = d.word0[`ETD_CHAIN_BIT];
        d.use_chain                 = d.word0[`ETD_CHAIN_BIT]
                                      & ~d.word0[`ETD_WRAP_BIT];
    end
endmodule

// >>> verilog/etd_tx_desc.sv
`include "etd_cfg.svh"
module etd_tx_desc (
    // Clock and reset.
    input  wire logic                core_clk_i,
    input  wire logic                rst_i,
    // Register port.
    input  wire logic [7:0]          reg_addr_i,
    input  wire logic [31:0]         reg_wdata_i,
    input  wire logic                reg_wr_i,
    input  wire logic                reg_rd_i,
    output logic      [31:0]         reg_rdata_o,
    // Descriptor memory port.
    output logic                     mem_rd_o,
    output logic                     mem_wr_o,
    output logic      [31:0]         mem_addr_o,
    output logic      [31:0]         mem_wdata_o,
    input  wire logic [31:0]         mem_rdata_i,
    input  wire logic                mem_rvalid_i,
    // Buffer hand-off to the transmit path.
    output logic                     buf_valid_o,
    output logic      [31:0]         buf_addr_o,
    output logic      [12:0]         buf_len_o,
    output logic                     buf_first_o,
    output logic                     buf_last_o,
    input  wire logic                buf_done_i,
    input  wire logic                frame_sent_i,
    // Per-frame options toward the MAC.
    output logic                     frame_start_o,
    output logic                     crc_append_o,
    output logic                     pad_enable_o,
    output logic                     pad_crc_o,
    output logic                     tx_stamp_o,
    output logic                     crc_overwrite_o,
    output logic      [1:0]          csum_mode_o,
    // Status.
    output logic                     tx_done_o,
    output logic                     suspended_o
);
    etd_dec_if dec_if ();

    etd_pkg::etd_state_t state, next_state;
    logic [1:0]  idx, next_idx;
    logic        bsel, next_bsel;
    logic [31:0] cur_addr, next_cur_addr;
    logic [31:0] base_addr, next_base_addr;
    logic        ctrl_en, next_ctrl_en;
    logic [31:0] desc_w [0:3];
    logic [31:0] next_desc_w [0:3];
    logic        next_mem_rd, next_mem_wr;
    logic [31:0] next_mem_addr, next_mem_wdata, next_rdata;
    logic        next_buf_valid, next_buf_first, next_buf_last;
    logic [31:0] next_buf_addr;
    logic [12:0] next_buf_len;
    logic        next_frame_start, next_crc_append, next_pad_enable, next_pad_crc;
    logic        next_tx_stamp, next_crc_overwrite, next_tx_done;
    logic [1:0]  next_csum_mode;
    logic [12:0] size1, size2;
    logic        word0_arrives;

    assign word0_arrives = (state == etd_pkg::ETD_RWAIT) && mem_rvalid_i && (idx == 2'h0);
    assign dec_if.word0  = word0_arrives ? mem_rdata_i : desc_w[0];
    assign size1 = desc_w[1][`ETD_SIZE1_MSB:`ETD_SIZE1_LSB];
    assign size2 = desc_w[1][`ETD_SIZE2_MSB:`ETD_SIZE2_LSB];

    etd_word0_dec u_dec (
        .d (dec_if.dec)
    );

    always_comb begin
        logic fin;
        fin = 1'b0;
        next_state         = state;
        next_idx           = idx;
        next_bsel          = bsel;
        next_cur_addr      = cur_addr;
        next_base_addr     = base_addr;
        next_ctrl_en       = ctrl_en;
        next_desc_w        = desc_w;
        next_mem_rd        = 1'b0;
        next_mem_wr        = 1'b0;
        next_mem_addr      = mem_addr_o;
        next_mem_wdata     = mem_wdata_o;
        next_rdata         = 32'h0000_0000;
        next_buf_valid     = buf_valid_o;
        next_buf_addr      = buf_addr_o;
        next_buf_len       = buf_len_o;
        next_buf_first     = buf_first_o;
        next_buf_last      = buf_last_o;
        next_frame_start   = 1'b0;
        next_crc_append    = crc_append_o;
        next_pad_enable    = pad_enable_o;
        next_pad_crc       = pad_crc_o;
        next_tx_stamp      = tx_stamp_o;
        next_crc_overwrite = crc_overwrite_o;
        next_csum_mode     = csum_mode_o;
        next_tx_done       = tx_done_o;

        if (reg_wr_i) begin
            unique case (reg_addr_i)
                `ETD_REG_CTRL: next_ctrl_en = reg_wdata_i[`ETD_CTRL_EN_BIT];
                `ETD_REG_BASE: begin
                    next_base_addr = reg_wdata_i;
                    if (state == etd_pkg::ETD_IDLE || state == etd_pkg::ETD_SUSP) begin
                        next_cur_addr = reg_wdata_i;
                    end
                end
                `ETD_REG_STATUS: begin
                    if (reg_wdata_i[`ETD_ST_DONE_BIT]) begin
                        next_tx_done = 1'b0;
                    end
                end
                default: ;
            endcase
        end
        if (reg_rd_i) begin
            unique case (reg_addr_i)
                `ETD_REG_CTRL:   next_rdata[`ETD_CTRL_EN_BIT] = ctrl_en;
                `ETD_REG_BASE:   next_rdata = base_addr;
                `ETD_REG_STATUS: begin
                    next_rdata[`ETD_ST_DONE_BIT] = tx_done_o;
                    next_rdata[`ETD_ST_SUSP_BIT] = suspended_o;
                end
                `ETD_REG_CUR:    next_rdata = cur_addr;
                default: ;
            endcase
        end

        unique case (state)
            etd_pkg::ETD_IDLE: begin
                if (ctrl_en) begin
                    next_idx   = 2'h0;
                    next_state = etd_pkg::ETD_RD;
                end
            end
            etd_pkg::ETD_RD: begin
                next_mem_rd   = 1'b1;
                next_mem_addr = cur_addr + {28'h0000_000, idx, 2'h0};
                next_state    = etd_pkg::ETD_RWAIT;
            end
            etd_pkg::ETD_RWAIT: begin
                if (mem_rvalid_i) begin
                    next_desc_w[idx] = mem_rdata_i;
                    next_idx         = idx + 2'h1;
                    next_state       = (idx == 2'h3) ? etd_pkg::ETD_BUF : etd_pkg::ETD_RD;
                    if (idx == 2'h0) begin
                        // A host-owned word stops the walk; nothing of it is acted on.
                        if (!dec_if.own) begin
                            next_state = etd_pkg::ETD_SUSP;
                        end else if (dec_if.initial_segment_flag) begin
                            next_frame_start   = 1'b1;
                            next_crc_append    = dec_if.crc_append;
                            next_pad_enable    = dec_if.pad_enable;
                            next_pad_crc       = dec_if.pad_crc;
                            next_tx_stamp      = dec_if.tx_stamp_request;
                            next_crc_overwrite = dec_if.crc_overwrite_request;
                            next_csum_mode     = dec_if.checksum_insert_mode;
                        end
                    end
                    next_bsel = 1'b0;
                end
            end
            etd_pkg::ETD_BUF: begin
                if (buf_valid_o) begin
                    if (buf_done_i) begin
                        next_buf_valid = 1'b0;
                        next_bsel      = 1'b1;
                        fin            = bsel;
                    end
                end else if (!bsel) begin
                    if (size1 != 13'h0000) begin
                        next_buf_valid = 1'b1;
                        next_buf_addr  = desc_w[2];
                        next_buf_len   = size1;
                    end else begin
                        next_bsel = 1'b1;
                    end
                end else if (!dec_if.use_chain && size2 != 13'h0000) begin
                    next_buf_valid = 1'b1;
                    next_buf_addr  = desc_w[3];
                    next_buf_len   = size2;
                end else begin
                    fin = 1'b1;
                end
                next_buf_first = dec_if.initial_segment_flag;
                next_buf_last  = dec_if.final_segment_flag;
                if (fin) begin
                    next_state = dec_if.final_segment_flag ? etd_pkg::ETD_SENT
                                                           : etd_pkg::ETD_WB;
                end
            end
            etd_pkg::ETD_SENT: begin
                if (frame_sent_i) begin
                    if (dec_if.irq_when_sent) begin
                        next_tx_done = 1'b1;
                    end
                    next_state = etd_pkg::ETD_WB;
                end
            end
            etd_pkg::ETD_WB: begin
                next_mem_wr    = 1'b1;
                next_mem_addr  = cur_addr;
                next_mem_wdata = desc_w[0] & ~(32'h0000_0001 << `ETD_OWN_BIT);
                if (dec_if.ring_wrap_flag) begin
                    next_cur_addr = base_addr;
                end else if (dec_if.use_chain) begin
                    next_cur_addr = desc_w[3];
                end else begin
                    next_cur_addr = cur_addr + `ETD_DESC_BYTES;
                end
                next_idx   = 2'h0;
                next_state = ctrl_en ? etd_pkg::ETD_RD : etd_pkg::ETD_IDLE;
            end
            etd_pkg::ETD_SUSP: begin
                if (reg_wr_i && reg_addr_i == `ETD_REG_POLL) begin
                    next_idx   = 2'h0;
                    next_state = etd_pkg::ETD_RD;
                end else if (!ctrl_en) begin
                    next_state = etd_pkg::ETD_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            state           <= etd_pkg::ETD_IDLE;
            idx             <= 2'h0;
            bsel            <= 1'b0;
            cur_addr        <= `ETD_RST_BASE;
            base_addr       <= `ETD_RST_BASE;
            ctrl_en         <= 1'b0;
            for (int i = 0; i < 4; i++) begin
                desc_w[i] <= 32'h0000_0000;
            end
            mem_rd_o        <= 1'b0;
            mem_wr_o        <= 1'b0;
            mem_addr_o      <= 32'h0000_0000;
            mem_wdata_o     <= 32'h0000_0000;
            reg_rdata_o     <= 32'h0000_0000;
            buf_valid_o     <= 1'b0;
            buf_addr_o      <= 32'h0000_0000;
            buf_len_o       <= 13'h0000;
            buf_first_o     <= 1'b0;
            buf_last_o      <= 1'b0;
            frame_start_o   <= 1'b0;
            crc_append_o    <= 1'b1;
            pad_enable_o    <= 1'b1;
            pad_crc_o       <= 1'b1;
            tx_stamp_o      <= 1'b0;
            crc_overwrite_o <= 1'b0;
            csum_mode_o     <= 2'h0;
            tx_done_o       <= 1'b0;
            suspended_o     <= 1'b0;
        end else begin
            state           <= next_state;
            idx             <= next_idx;
            bsel            <= next_bsel;
            cur_addr        <= next_cur_addr;
            base_addr       <= next_base_addr;
            ctrl_en         <= next_ctrl_en;
            desc_w          <= next_desc_w;
            mem_rd_o        <= next_mem_rd;
            mem_wr_o        <= next_mem_wr;
            mem_addr_o      <= next_mem_addr;
            mem_wdata_o     <= next_mem_wdata;
            reg_rdata_o     <= next_rdata;
            buf_valid_o     <= next_buf_valid;
            buf_addr_o      <= next_buf_addr;
            buf_len_o       <= next_buf_len;
            buf_first_o     <= next_buf_first;
            buf_last_o      <= next_buf_last;
            frame_start_o   <= next_frame_start;
            crc_append_o    <= next_crc_append;
            pad_enable_o    <= next_pad_enable;
            pad_crc_o       <= next_pad_crc;
            tx_stamp_o      <= next_tx_stamp;
            crc_overwrite_o <= next_crc_overwrite;
            csum_mode_o     <= next_csum_mode;
            tx_done_o       <= next_tx_done;
            suspended_o     <= (next_state == etd_pkg::ETD_SUSP);
        end
    end
endmodule

// >>> sim/etd_host_mem.sv
module etd_host_mem (
    // Clock, reset and pace.
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        slow_i,
    // Descriptor memory side.
    input  wire logic        rd_i,
    input  wire logic        wr_i,
    input  wire logic [31:0] addr_i,
    input  wire logic [31:0] wdata_i,
    output logic      [31:0] rdata_o,
    output logic             rvalid_o,
    // Transmit path side.
    input  wire logic        buf_valid_i,
    input  wire logic        buf_last_i,
    output logic             buf_done_o,
    output logic             frame_sent_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] mem [0:63];
    int          rcnt;
    int          bcnt;
    int          fcnt;
    int          buf_count;
    // Read data toggles when not valid so a stale sample never looks right.
    always @(posedge clk_i) begin
        rvalid_o <= 1'b0;
        buf_done_o <= 1'b0;
        frame_sent_o <= 1'b0;
        rdata_o <= rst_i ? 32'h0f0f_0f0f : ~rdata_o;
        if (wr_i) begin
            mem[addr_i[7:2]] <= wdata_i;
        end
        if (rst_i) begin
            rcnt <= 0;
        end else if (rd_i) begin
            rcnt <= slow_i ? 4 : 1;
        end else if (rcnt == 1) begin
            rvalid_o <= 1'b1;
            rdata_o <= mem[addr_i[7:2]];
            rcnt <= 0;
        end else if (rcnt > 1) begin
            rcnt <= rcnt - 1;
        end
        if (fcnt == 1) begin
            frame_sent_o <= 1'b1;
        end
        if (fcnt > 0) begin
            fcnt <= fcnt - 1;
        end
        if (rst_i) begin
            bcnt <= 0;
        end else if (buf_valid_i && !buf_done_o) begin
            bcnt <= bcnt + 1;
            if (bcnt == (slow_i ? 3 : 0)) begin
                buf_done_o <= 1'b1;
                bcnt <= 0;
                buf_count <= buf_count + 1;
                fcnt <= buf_last_i ? 2 : 0;
            end
        end
    end
endmodule

// >>> sim/etd_tx_desc_assertions.sv
module etd_tx_desc_assertions (
    input wire logic        core_clk_i,
    input wire logic        rst_i,
    input wire logic        mem_rd_o,
    input wire logic        mem_wr_o,
    input wire logic [31:0] mem_addr_o,
    input wire logic [31:0] mem_wdata_o,
    input wire logic        buf_valid_o,
    input wire logic        frame_sent_i,
    input wire logic        frame_start_o,
    input wire logic        crc_append_o,
    input wire logic        pad_enable_o,
    input wire logic        pad_crc_o,
    input wire logic        tx_stamp_o,
    input wire logic        crc_overwrite_o,
    input wire logic [1:0]  csum_mode_o,
    input wire logic        tx_done_o,
    input wire logic        suspended_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    logic [2:0]  rd_idx;
    logic [31:0] rd_base;
    // Word index within the descriptor now being fetched.
    always_ff @(posedge core_clk_i) begin
        if (rst_i || mem_wr_o || suspended_o) begin
            rd_idx <= 3'h0;
        end else if (mem_rd_o) begin
            rd_idx <= rd_idx + 3'h1;
            rd_base <= (rd_idx == 3'h0) ? mem_addr_o : rd_base;
        end
    end
    sequence s_done_rise;
        !tx_done_o ##1 tx_done_o;
    endsequence
    sequence s_held;
        suspended_o [*2];
    endsequence
    chk_word_stride: assert property (mem_rd_o && rd_idx != 3'h0 |->
        mem_addr_o == rd_base + {27'h0, rd_idx, 2'b00}) else $error("descriptor word address off");
    chk_word_limit: assert property (mem_rd_o |-> rd_idx < 3'h4)
        else $error("descriptor word read beyond word three");
    chk_wb_release: assert property (mem_wr_o |-> mem_addr_o == rd_base && !mem_wdata_o[31])
        else $error("write-back wrong address or owner kept");
    chk_pad_crc: assert property (pad_crc_o == pad_enable_o)
        else $error("pad crc differs from pad enable");
    chk_overwrite_gate: assert property (crc_overwrite_o |-> !crc_append_o)
        else $error("overwrite without crc disable");
    chk_opts_latch: assert property (!$stable({crc_append_o, pad_enable_o, tx_stamp_o,
        crc_overwrite_o, csum_mode_o}) |-> frame_start_o || $past(frame_start_o))
        else $error("frame options changed outside a frame start");
    chk_done_cause: assert property (s_done_rise |-> $past(frame_sent_i))
        else $error("done rose without a frame sent");
    chk_susp_quiet: assert property (s_held |-> !mem_rd_o && !buf_valid_o)
        else $error("activity while halted on a host descriptor");
endmodule
bind etd_tx_desc etd_tx_desc_assertions etd_tx_desc_assertions_inst (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .mem_rd_o(mem_rd_o), .mem_wr_o(mem_wr_o),
    .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o), .buf_valid_o(buf_valid_o),
    .frame_sent_i(frame_sent_i), .frame_start_o(frame_start_o), .crc_append_o(crc_append_o),
    .pad_enable_o(pad_enable_o), .pad_crc_o(pad_crc_o), .tx_stamp_o(tx_stamp_o),
    .crc_overwrite_o(crc_overwrite_o), .csum_mode_o(csum_mode_o), .tx_done_o(tx_done_o),
    .suspended_o(suspended_o));

// >>> sim/tb_eth_tx_descriptor_word0_control.sv
`include "etd_cfg.svh"
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin bad_count++; \
    $display("wrong value %s expected %h seen %h", nm, (e), (g)); end end
module tb_eth_tx_descriptor_word0_control;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [31:0] w0; logic [6:0] exp;} etd_row_t;
    localparam logic [31:0] own_b = 32'h8000_0000, fl_b = 32'h3000_0000, first_b = 32'h1000_0000;
    localparam logic [31:0] last_b = 32'h2000_0000, wrap_b = 32'h0020_0000, chain_b = 32'h0010_0000;
    logic        core_clk_i, rst_i, reg_wr_i, reg_rd_i, slow;
    logic [7:0]  reg_addr_i;
    logic [31:0] reg_wdata_i, reg_rdata_o, mem_addr_o, mem_wdata_o, mem_rdata_i, buf_addr_o;
    logic        mem_rd_o, mem_wr_o, mem_rvalid_i, buf_valid_o, buf_first_o, buf_last_o;
    logic        buf_done_i, frame_sent_i, frame_start_o, crc_append_o, pad_enable_o;
    logic        pad_crc_o, tx_stamp_o, crc_overwrite_o, tx_done_o, suspended_o;
    logic [12:0] buf_len_o;
    logic [1:0]  csum_mode_o;
    int          bad_count, comparisons, nb;
    wire  [6:0]  opts = {crc_append_o, pad_enable_o, pad_crc_o, tx_stamp_o, crc_overwrite_o,
                         csum_mode_o};
    wire  [46:0] bufv = {buf_addr_o, buf_len_o, buf_first_o, buf_last_o};
    etd_row_t    rows [4] = '{'{32'h4900_0000, 7'h34}, '{32'h0640_0000, 7'h49},
                              '{32'h4180_0000, 7'h72}, '{32'h0cc0_0000, 7'h03}};
    etd_tx_desc etd_tx_desc_inst (.core_clk_i(core_clk_i), .rst_i(rst_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .mem_rd_o(mem_rd_o), .mem_wr_o(mem_wr_o),
        .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o), .mem_rdata_i(mem_rdata_i),
        .mem_rvalid_i(mem_rvalid_i), .buf_valid_o(buf_valid_o), .buf_addr_o(buf_addr_o),
        .buf_len_o(buf_len_o), .buf_first_o(buf_first_o), .buf_last_o(buf_last_o),
        .buf_done_i(buf_done_i), .frame_sent_i(frame_sent_i), .frame_start_o(frame_start_o),
        .crc_append_o(crc_append_o), .pad_enable_o(pad_enable_o), .pad_crc_o(pad_crc_o),
        .tx_stamp_o(tx_stamp_o), .crc_overwrite_o(crc_overwrite_o), .csum_mode_o(csum_mode_o),
        .tx_done_o(tx_done_o), .suspended_o(suspended_o));
    etd_host_mem etd_host_mem_inst (.clk_i(core_clk_i), .rst_i(rst_i), .slow_i(slow),
        .rd_i(mem_rd_o), .wr_i(mem_wr_o), .addr_i(mem_addr_o), .wdata_i(mem_wdata_o),
        .rdata_o(mem_rdata_i), .rvalid_o(mem_rvalid_i), .buf_valid_i(buf_valid_o),
        .buf_last_i(buf_last_o), .buf_done_o(buf_done_i), .frame_sent_o(frame_sent_i));
    initial begin
        core_clk_i = 1'b0;
        forever #2 core_clk_i = ~core_clk_i;
    end
    task stop_test;
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge core_clk_i);
        reg_wr_i <= 1'b0;
    endtask
    task reg_read(input logic [7:0] a, input logic [31:0] e, input string nm);
        @(posedge core_clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge core_clk_i);
        reg_rd_i <= 1'b0;
        #1 `CHK(nm, e, reg_rdata_o)
    endtask
    task wait_susp(input logic v);
        int n;
        n = 0;
        while (suspended_o !== v && n < 500) begin
            @(posedge core_clk_i);
            #1 n++;
        end
        `CHK("suspend wait", v, suspended_o)
    endtask
    // Word 0 goes in last, so the engine never sees a half-built descriptor.
    task put(input int a, input logic [31:0] w0, w1, w2, w3);
        etd_host_mem_inst.mem[a+3] = w3;
        etd_host_mem_inst.mem[a+2] = w2;
        etd_host_mem_inst.mem[a+1] = w1;
        etd_host_mem_inst.mem[a] = w0;
        nb = etd_host_mem_inst.buf_count;
    endtask
    task go(input logic [31:0] base);
        reg_write(`ETD_REG_BASE, base);
        reg_write(`ETD_REG_CTRL, 32'h1);
        reg_write(`ETD_REG_POLL, 32'h0);
        wait_susp(1'b0);
        wait_susp(1'b1);
    endtask
    initial begin
        #(4 * 20000);
        bad_count++;
        $display("wrong value watchdog expected finish seen hang");
        stop_test();
    end
    initial begin
        {rst_i, reg_wr_i, reg_rd_i, slow, reg_addr_i, reg_wdata_i} = {1'b1, 43'h0};
        {bad_count, comparisons} = 0;
        repeat (4) @(posedge core_clk_i);
        rst_i <= 1'b0;
        #1 `CHK("reset", 9'h1c0, {opts, tx_done_o, suspended_o})
        reg_read(8'h30, 32'h0, "unmapped");
        for (int i = 0; i < 4; i++) begin
            slow <= i[0];
            put(16, 32'h0, 32'h0, 32'h0, 32'h0);
            put(0, rows[i].w0 | own_b | fl_b | chain_b, 32'h0008_0010, 32'h100, 32'h40);
            go(32'h0);
            `CHK("options", rows[i].exp, opts)
            `CHK("owner", 1'b0, etd_host_mem_inst.mem[0][31])
            `CHK("buffers", 1, etd_host_mem_inst.buf_count - nb)
            `CHK("buf one", {32'h100, 13'h10, 2'b11}, bufv)
            reg_read(`ETD_REG_STATUS, {29'h0, 2'b10, rows[i].w0[30]}, "status");
            reg_write(`ETD_REG_STATUS, 32'h1);
            reg_read(`ETD_REG_CUR, 32'h40, "next");
            $display("row %0d done", i);
        end
        put(32, 32'h0, 32'h0, 32'h0, 32'h0);
        put(16, own_b | last_b | chain_b | 32'h0980_0000, 32'h0008_0010, 32'h140, 32'h80);
        put(0, own_b | first_b | chain_b | 32'h4640_0000, 32'h0008_0010, 32'h100, 32'h40);
        go(32'h0);
        `CHK("held options", 7'h49, opts)
        `CHK("two buffers", 2, etd_host_mem_inst.buf_count - nb)
        reg_read(`ETD_REG_STATUS, 32'h4, "no done");
        reg_read(`ETD_REG_CUR, 32'h80, "chain");
        $display("test segments done");
        put(8, 32'h0, 32'h0, 32'h0, 32'h0);
        put(32, own_b | fl_b | chain_b, 32'h10, 32'h100, 32'h40);
        put(0, own_b | fl_b | wrap_b | chain_b, 32'h10, 32'h100, 32'h80);
        go(32'h0);
        reg_read(`ETD_REG_CUR, 32'h0, "wrap");
        `CHK("skipped", 1'b1, etd_host_mem_inst.mem[32][31])
        $display("test wrap done");
        put(24, 32'h0, 32'h0, 32'h0, 32'h0);
        put(16, own_b | first_b, 32'h0008_0010, 32'h100, 32'h180);
        go(32'h40);
        reg_read(`ETD_REG_CUR, 32'h60, "stride");
        `CHK("second buffer", 2, etd_host_mem_inst.buf_count - nb)
        `CHK("buf two", {32'h180, 13'h8, 2'b10}, bufv)
        repeat (20) @(posedge core_clk_i);
        `CHK("halted", 1'b1, suspended_o)
        rst_i <= 1'b1;
        repeat (2) @(posedge core_clk_i);
        rst_i <= 1'b0;
        #1 `CHK("reset again", 9'h1c0, {opts, tx_done_o, suspended_o})
        $display("test halt and reset done");
        stop_test();
    end
endmodule
